// *** verilog/ctsup_pkg.sv ***
/*
 * Package for the current transformer wiring supervisor: register map,
 * field positions, reset values, timing counts and the carrier structs.
 * Assumes measurement words are unsigned magnitudes in units of 0.01 x In
 * and ratio settings in units of 0.01 percent.
 */
package ctsup_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CUR_W = 16;
	localparam int unsigned RAT_W = 14;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned HIST_DEPTH = 12;
	localparam int unsigned HIST_IDX_W = 4;
	localparam int unsigned HIST_WORDS = 6;
	localparam int unsigned WORD_SEL_W = 3;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_HIGH_LIM = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_LOW_LIM = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PHASE_RATIO = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_SEQ_RATIO = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SUM_DIFF = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_ALARM_DELAY = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_RELEASE_DELAY = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_TIMER = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_HIST_SEL = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_HIST_DATA = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_HIST_INFO = 8'h30;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_RES_EN = 0;
	localparam int unsigned CTRL_RES_SEL = 1;
	localparam int unsigned CTRL_FORCE_EN = 2;
	localparam int unsigned CTRL_SW_BLOCK = 3;
	localparam int unsigned CTRL_EVT_ON_EN = 4;
	localparam int unsigned CTRL_EVT_OFF_EN = 5;
	localparam int unsigned CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h30;

	// ----------------------------------------------------------------
	// Setting reset values
	// ----------------------------------------------------------------
	localparam logic [CUR_W-1:0] HIGH_LIM_RESET = 16'h0078;
	localparam logic [CUR_W-1:0] LOW_LIM_RESET = 16'h000A;
	localparam logic [RAT_W-1:0] PHASE_RATIO_RESET = 14'h03E8;
	localparam logic [RAT_W-1:0] SEQ_RATIO_RESET = 14'h1324;
	localparam logic [CUR_W-1:0] SUM_DIFF_RESET = 16'h000A;
	localparam logic [RAT_W-1:0] RATIO_FULL = 14'h2710;

	// ----------------------------------------------------------------
	// Timing: one processing cycle per delay step
	// ----------------------------------------------------------------
	localparam int unsigned CYCLE_PERIOD_MS = 5;
	localparam int unsigned ALARM_DELAY_MS = 500;
	localparam int unsigned BLOCK_LEAD_MS = 5;
	localparam logic [CNT_W-1:0] ALARM_DELAY_RESET = CNT_W'(ALARM_DELAY_MS / CYCLE_PERIOD_MS);
	localparam logic [CNT_W-1:0] RELEASE_DELAY_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Event codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CTSUP_EV_ALARM_ON = 2'b00,
		CTSUP_EV_ALARM_OFF = 2'b01,
		CTSUP_EV_BLOCK_ON = 2'b10,
		CTSUP_EV_BLOCK_OFF = 2'b11
	} ctsup_evcode_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [CUR_W-1:0] il1;
		logic [CUR_W-1:0] il2;
		logic [CUR_W-1:0] il3;
		logic [CUR_W-1:0] i01;
		logic [CUR_W-1:0] i02;
		logic [CUR_W-1:0] ipos;
		logic [CUR_W-1:0] ineg;
		logic [CUR_W-1:0] isum;
	} ctsup_meas_t;

	typedef struct packed {
		logic [31:0] stamp;
		ctsup_evcode_t code;
		logic [2:0] fault;
		ctsup_meas_t meas;
	} ctsup_evt_t;

	typedef struct packed {
		logic [31:0] stamp;
		ctsup_evcode_t code;
		ctsup_meas_t meas;
		logic [CNT_W-1:0] remain;
		logic [2:0] fault;
		logic [2:0] settings_bank;
	} ctsup_rec_t;

endpackage

// *** verilog/ctsup_supervisor.sv ***
/*
 * Current transformer wiring supervisor: pick-up evaluation, block check,
 * fixed delay alarm with release, on/off events and a twelve entry history.
 * Assumes CYCLE_STB is a one clock pulse per processing cycle, at least
 * four clocks apart, and that MEAS, TIME_NOW and SETTINGS_BANK are stable
 * on the clock domain. BLOCK_IN is an asynchronous pin.
 */
// Design decisions made here: the address-and-strobe port and the register addresses.
// Functional notes
// - Block input sampled once at each processing cycle start, used for that cycle.
// - Pick-up without blocking asserts start and runs the alarm delay.
// - Pick-up with blocking asserts blocked, no timing or alarm.
// - Blocking during start drops start and runs release timing as on drop-out.
// - Entering blocked gives a notify pulse and a block event with start-up currents.
// - Test forcing mode lets a software switch drive blocking.
// - Only fixed delay for operate and release, no inverse curves.
// - Alarm only if all conditions persist for the whole delay.
// - Any phase above the upper threshold suppresses activation.
// - All phases below the lower threshold suppress activation.
// - Residual selected adds summed versus measured residual comparison.
// - Residual difference below its limit prevents activation.
// - Without residual check, alarm regardless of primary or secondary cause.
// - On and off events for alarm and blocked, masked by on/off selects.
// - Each event carries timestamp and measurements captured at the event; block on events carry the start-up currents.
// - Circular history of the last 12 records, oldest overwritten.
// - Record holds time, event, currents, time remaining, fault code, settings bank.
// - Alarm delay configurable, default half a second.
// - Min to max phase ratio threshold, default ten percent, required.
// - Negative to positive sequence ratio threshold, typical 49 percent, required.
`timescale 1ns/100ps

module ctsup_supervisor #(
	parameter int unsigned HIST_DEPTH = ctsup_pkg::HIST_DEPTH
) (
	// Clock, reset, enable
	input wire logic CLOCK,
	input wire logic ARST_N,
	input wire logic CE,
	// Processing cycle and inputs
	input wire logic CYCLE_STB,
	input wire logic BLOCK_IN,
	input wire ctsup_pkg::ctsup_meas_t MEAS,
	input wire logic [31:0] TIME_NOW,
	input wire logic [2:0] SETTINGS_BANK,
	// Register port
	input wire logic [ctsup_pkg::ADDR_W-1:0] ADDR,
	input wire logic [ctsup_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [ctsup_pkg::DATA_W-1:0] RDATA,
	// Supervision outputs
	output logic START,
	output logic ALARM,
	output logic BLOCKED,
	output logic NOTIFY,
	// Event stream
	output logic EVT_VALID,
	output ctsup_pkg::ctsup_evt_t EVT
);

	// ----------------------------------------------------------------
	// Settings registers
	// ----------------------------------------------------------------
	logic [ctsup_pkg::CTRL_W-1:0] ctrl_q;
	logic [ctsup_pkg::CUR_W-1:0] high_lim_q;
	logic [ctsup_pkg::CUR_W-1:0] low_lim_q;
	logic [ctsup_pkg::RAT_W-1:0] phase_ratio_q;
	logic [ctsup_pkg::RAT_W-1:0] seq_ratio_q;
	logic [ctsup_pkg::CUR_W-1:0] sum_diff_q;
	logic [ctsup_pkg::CNT_W-1:0] alarm_delay_q;
	logic [ctsup_pkg::CNT_W-1:0] release_delay_q;
	logic [ctsup_pkg::HIST_IDX_W-1:0] hist_sel_idx_q;
	logic [ctsup_pkg::WORD_SEL_W-1:0] hist_sel_word_q;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_q <= ctsup_pkg::CTRL_RESET;
			high_lim_q <= ctsup_pkg::HIGH_LIM_RESET;
			low_lim_q <= ctsup_pkg::LOW_LIM_RESET;
			phase_ratio_q <= ctsup_pkg::PHASE_RATIO_RESET;
			seq_ratio_q <= ctsup_pkg::SEQ_RATIO_RESET;
			sum_diff_q <= ctsup_pkg::SUM_DIFF_RESET;
			alarm_delay_q <= ctsup_pkg::ALARM_DELAY_RESET;
			release_delay_q <= ctsup_pkg::RELEASE_DELAY_RESET;
			hist_sel_idx_q <= '0;
			hist_sel_word_q <= '0;
		end else if (CE && WR) begin
			unique case (ADDR)
				ctsup_pkg::OFS_CTRL: ctrl_q <= WDATA[ctsup_pkg::CTRL_W-1:0];
				ctsup_pkg::OFS_HIGH_LIM: high_lim_q <= WDATA[ctsup_pkg::CUR_W-1:0];
				ctsup_pkg::OFS_LOW_LIM: low_lim_q <= WDATA[ctsup_pkg::CUR_W-1:0];
				ctsup_pkg::OFS_PHASE_RATIO: phase_ratio_q <= WDATA[ctsup_pkg::RAT_W-1:0];
				ctsup_pkg::OFS_SEQ_RATIO: seq_ratio_q <= WDATA[ctsup_pkg::RAT_W-1:0];
				ctsup_pkg::OFS_SUM_DIFF: sum_diff_q <= WDATA[ctsup_pkg::CUR_W-1:0];
				ctsup_pkg::OFS_ALARM_DELAY: alarm_delay_q <= WDATA[ctsup_pkg::CNT_W-1:0];
				ctsup_pkg::OFS_RELEASE_DELAY: release_delay_q <= WDATA[ctsup_pkg::CNT_W-1:0];
				ctsup_pkg::OFS_HIST_SEL: begin
					hist_sel_idx_q <= WDATA[ctsup_pkg::HIST_IDX_W-1:0];
					hist_sel_word_q <= WDATA[8 +: ctsup_pkg::WORD_SEL_W];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Block pin synchroniser
	// ----------------------------------------------------------------
	logic blk_s1_q;
	logic blk_s2_q;
	logic blk_s3_q;
	logic blk_pin_q;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			blk_s1_q <= 1'b0;
			blk_s2_q <= 1'b0;
			blk_s3_q <= 1'b0;
			blk_pin_q <= 1'b0;
		end else if (CE) begin
			blk_s1_q <= BLOCK_IN;
			blk_s2_q <= blk_s1_q;
			blk_s3_q <= blk_s2_q;
			if (blk_s2_q == blk_s3_q) begin
				blk_pin_q <= blk_s3_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pick-up evaluation
	// ----------------------------------------------------------------
	logic [ctsup_pkg::CUR_W-1:0] imin;
	logic [ctsup_pkg::CUR_W-1:0] imax;
	logic [ctsup_pkg::CUR_W-1:0] ires;
	logic [ctsup_pkg::CUR_W-1:0] rdiff;
	logic over_high;
	logic all_low;
	logic ratio_ok;
	logic seq_ok;
	logic resid_ok;
	logic pickup;
	logic blk_now;
	logic [2:0] fault;

	always_comb begin
		imin = MEAS.il1;
		imax = MEAS.il1;
		if (MEAS.il2 < imin) imin = MEAS.il2;
		if (MEAS.il3 < imin) imin = MEAS.il3;
		if (MEAS.il2 > imax) imax = MEAS.il2;
		if (MEAS.il3 > imax) imax = MEAS.il3;
		ires = ctrl_q[ctsup_pkg::CTRL_RES_SEL] ? MEAS.i02 : MEAS.i01;
		rdiff = (MEAS.isum > ires) ? MEAS.isum - ires : ires - MEAS.isum;
	end

	assign over_high = (MEAS.il1 > high_lim_q) || (MEAS.il2 > high_lim_q)
		|| (MEAS.il3 > high_lim_q);
	assign all_low = (MEAS.il1 < low_lim_q) && (MEAS.il2 < low_lim_q)
		&& (MEAS.il3 < low_lim_q);
	assign ratio_ok = (32'(imin) * 32'(ctsup_pkg::RATIO_FULL))
		<= (32'(imax) * 32'(phase_ratio_q));
	assign seq_ok = (32'(MEAS.ineg) * 32'(ctsup_pkg::RATIO_FULL))
		>= (32'(MEAS.ipos) * 32'(seq_ratio_q));
	assign resid_ok = !ctrl_q[ctsup_pkg::CTRL_RES_EN] || (rdiff >= sum_diff_q);
	assign pickup = !over_high && !all_low && ratio_ok && seq_ok && resid_ok;
	assign fault = {resid_ok, all_low, over_high};
	assign blk_now = ctrl_q[ctsup_pkg::CTRL_FORCE_EN] ? ctrl_q[ctsup_pkg::CTRL_SW_BLOCK]
		: blk_pin_q;

	// ----------------------------------------------------------------
	// Cycle sampling and start-up capture
	// ----------------------------------------------------------------
	logic blk_smp_q;
	logic pick_q;
	ctsup_pkg::ctsup_meas_t start_meas_q;
	ctsup_pkg::ctsup_meas_t start_meas;
	ctsup_pkg::ctsup_meas_t snap_meas_q;
	logic [31:0] snap_time_q;
	logic [2:0] snap_fault_q;
	logic [2:0] start_fault_q;

	assign start_meas = pick_q ? start_meas_q : MEAS;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			blk_smp_q <= 1'b0;
			pick_q <= 1'b0;
			start_meas_q <= '0;
			snap_meas_q <= '0;
			snap_time_q <= '0;
			snap_fault_q <= '0;
			start_fault_q <= '0;
		end else if (CE && CYCLE_STB) begin
			blk_smp_q <= blk_now;
			pick_q <= pickup;
			snap_meas_q <= MEAS;
			snap_time_q <= TIME_NOW;
			snap_fault_q <= fault;
			if (pickup && !pick_q) begin
				start_meas_q <= MEAS;
				start_fault_q <= fault;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fixed delay timing and outputs
	// ----------------------------------------------------------------
	logic [ctsup_pkg::CNT_W-1:0] cnt_q;
	logic [ctsup_pkg::CNT_W-1:0] rel_cnt_q;
	logic [ctsup_pkg::CNT_W-1:0] cnt_nx;
	logic [ctsup_pkg::CNT_W-1:0] rel_nx;
	logic run;
	logic blk_hit;
	logic alarm_set;
	logic alarm_clr;

	assign run = pickup && !blk_now;
	assign blk_hit = pickup && blk_now;
	assign cnt_nx = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
	assign rel_nx = (rel_cnt_q == '1) ? rel_cnt_q : rel_cnt_q + 1'b1;
	assign alarm_set = run && !ALARM && (cnt_nx >= alarm_delay_q);
	assign alarm_clr = !run && ALARM && (rel_nx >= release_delay_q);

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			cnt_q <= '0;
			rel_cnt_q <= '0;
			START <= 1'b0;
			ALARM <= 1'b0;
			BLOCKED <= 1'b0;
		end else if (CE && CYCLE_STB) begin
			START <= run;
			BLOCKED <= blk_hit;
			cnt_q <= run ? cnt_nx : '0;
			rel_cnt_q <= (run || !ALARM) ? '0 : rel_nx;
			if (alarm_set) begin
				ALARM <= 1'b1;
			end else if (alarm_clr) begin
				ALARM <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Event generation, one per clock in fixed order
	// ----------------------------------------------------------------
	logic [3:0] pend_q;
	logic [3:0] pend_new;
	logic [3:0] pend_msk;
	ctsup_pkg::ctsup_evcode_t pick_code;
	logic pick_any;

	assign pend_new = {BLOCKED && !blk_hit, !BLOCKED && blk_hit,
		alarm_clr, alarm_set};
	assign pend_msk = pend_new & {ctrl_q[ctsup_pkg::CTRL_EVT_OFF_EN],
		ctrl_q[ctsup_pkg::CTRL_EVT_ON_EN], ctrl_q[ctsup_pkg::CTRL_EVT_OFF_EN],
		ctrl_q[ctsup_pkg::CTRL_EVT_ON_EN]};
	assign pick_any = |pend_q;

	always_comb begin
		pick_code = ctsup_pkg::CTSUP_EV_ALARM_ON;
		if (pend_q[0]) pick_code = ctsup_pkg::CTSUP_EV_ALARM_ON;
		else if (pend_q[1]) pick_code = ctsup_pkg::CTSUP_EV_ALARM_OFF;
		else if (pend_q[2]) pick_code = ctsup_pkg::CTSUP_EV_BLOCK_ON;
		else if (pend_q[3]) pick_code = ctsup_pkg::CTSUP_EV_BLOCK_OFF;
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			pend_q <= '0;
			EVT_VALID <= 1'b0;
			EVT <= '0;
		end else if (CE) begin
			EVT_VALID <= pick_any && !CYCLE_STB;
			if (CYCLE_STB) begin
				pend_q <= pend_q | pend_msk;
			end else if (pick_any) begin
				pend_q <= pend_q & ~(4'h1 << pick_code);
				EVT.stamp <= snap_time_q;
				EVT.code <= pick_code;
				if (pick_code == ctsup_pkg::CTSUP_EV_BLOCK_ON) begin
					EVT.meas <= start_meas_q;
					EVT.fault <= start_fault_q;
				end else begin
					EVT.meas <= snap_meas_q;
					EVT.fault <= snap_fault_q;
				end
			end
		end
	end

	// Display notification on entry to blocked
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			NOTIFY <= 1'b0;
		end else if (CE) begin
			NOTIFY <= CYCLE_STB && blk_hit && !BLOCKED;
		end
	end

	// ----------------------------------------------------------------
	// Operation history
	// ----------------------------------------------------------------
	ctsup_pkg::ctsup_rec_t hist_mem [HIST_DEPTH];
	ctsup_pkg::ctsup_rec_t rec_new;
	logic [ctsup_pkg::HIST_IDX_W-1:0] wr_ptr_q;
	logic [ctsup_pkg::HIST_IDX_W-1:0] fill_q;
	logic rec_wr;

	assign rec_wr = CYCLE_STB && (alarm_set || (blk_hit && !BLOCKED));

	always_comb begin
		rec_new.stamp = TIME_NOW;
		rec_new.code = alarm_set ? ctsup_pkg::CTSUP_EV_ALARM_ON : ctsup_pkg::CTSUP_EV_BLOCK_ON;
		rec_new.meas = start_meas;
		rec_new.remain = (alarm_delay_q > cnt_nx) ? alarm_delay_q - cnt_nx : '0;
		rec_new.fault = fault;
		rec_new.settings_bank = SETTINGS_BANK;
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_ptr_q <= '0;
			fill_q <= '0;
		end else if (CE && rec_wr) begin
			wr_ptr_q <= (32'(wr_ptr_q) == HIST_DEPTH - 1) ? '0 : wr_ptr_q + 1'b1;
			if (32'(fill_q) < HIST_DEPTH) begin
				fill_q <= fill_q + 1'b1;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (CE && rec_wr) begin
			hist_mem[wr_ptr_q] <= rec_new;
		end
	end

	// ----------------------------------------------------------------
	// Register read path
	// ----------------------------------------------------------------
	logic [ctsup_pkg::HIST_WORDS*32-1:0] rec_bits;
	logic [ctsup_pkg::DATA_W-1:0] rd_mux;

	always_comb begin
		rec_bits = '0;
		if (32'(hist_sel_idx_q) < HIST_DEPTH) begin
			rec_bits[$bits(ctsup_pkg::ctsup_rec_t)-1:0] = hist_mem[hist_sel_idx_q];
		end
	end

	always_comb begin
		rd_mux = '0;
		unique case (ADDR)
			ctsup_pkg::OFS_CTRL: rd_mux[ctsup_pkg::CTRL_W-1:0] = ctrl_q;
			ctsup_pkg::OFS_HIGH_LIM: rd_mux[ctsup_pkg::CUR_W-1:0] = high_lim_q;
			ctsup_pkg::OFS_LOW_LIM: rd_mux[ctsup_pkg::CUR_W-1:0] = low_lim_q;
			ctsup_pkg::OFS_PHASE_RATIO: rd_mux[ctsup_pkg::RAT_W-1:0] = phase_ratio_q;
			ctsup_pkg::OFS_SEQ_RATIO: rd_mux[ctsup_pkg::RAT_W-1:0] = seq_ratio_q;
			ctsup_pkg::OFS_SUM_DIFF: rd_mux[ctsup_pkg::CUR_W-1:0] = sum_diff_q;
			ctsup_pkg::OFS_ALARM_DELAY: rd_mux[ctsup_pkg::CNT_W-1:0] = alarm_delay_q;
			ctsup_pkg::OFS_RELEASE_DELAY: rd_mux[ctsup_pkg::CNT_W-1:0] = release_delay_q;
			ctsup_pkg::OFS_STATUS: rd_mux[8:0] = {snap_fault_q, blk_smp_q, pick_q,
				BLOCKED, ALARM, START, blk_pin_q};
			ctsup_pkg::OFS_TIMER: rd_mux = {rel_cnt_q, cnt_q};
			ctsup_pkg::OFS_HIST_SEL: rd_mux[10:0] = {hist_sel_word_q, 4'h0, hist_sel_idx_q};
			ctsup_pkg::OFS_HIST_DATA: begin
				if (32'(hist_sel_word_q) < ctsup_pkg::HIST_WORDS) begin
					rd_mux = rec_bits[hist_sel_word_q * 32 +: 32];
				end
			end
			ctsup_pkg::OFS_HIST_INFO: rd_mux[11:0] = {fill_q, 4'h0, wr_ptr_q};
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			RDATA <= '0;
		end else if (CE) begin
			RDATA <= RD ? rd_mux : '0;
		end
	end

endmodule

// *** verif/ctsup_supervisor_assertions.sv ***
/*
 * Concurrent checks on the wiring supervisor ports.
 * Assumes one clock domain and CE held high by the bench.
 */
`timescale 1ns/100ps

module ctsup_supervisor_chk (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic ARST_N,
	// Inputs watched
	input wire logic CYCLE_STB,
	input wire logic RD,
	// Outputs watched
	input wire logic [ctsup_pkg::DATA_W-1:0] RDATA,
	input wire logic START,
	input wire logic ALARM,
	input wire logic BLOCKED,
	input wire logic NOTIFY,
	input wire logic EVT_VALID,
	input wire ctsup_pkg::ctsup_evt_t EVT
);
	logic [1:0] code;
	assign code = EVT.code;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);

	a_start_blk_excl: assert property (!(START && BLOCKED))
		else $error("start and blocked both high");
	a_start_at_cycle: assert property (!$stable(START) |-> $past(CYCLE_STB))
		else $error("start moved outside a cycle");
	a_blocked_at_cycle: assert property (!$stable(BLOCKED) |-> $past(CYCLE_STB))
		else $error("blocked moved outside a cycle");
	a_alarm_at_cycle: assert property (!$stable(ALARM) |-> $past(CYCLE_STB))
		else $error("alarm moved outside a cycle");
	a_notify_entry: assert property (NOTIFY == $rose(BLOCKED))
		else $error("notify not tied to blocked entry");
	a_alarm_needs_start: assert property ($rose(ALARM) |-> START)
		else $error("alarm without start");
	a_evt_slot: assert property (EVT_VALID |-> $past(CYCLE_STB, 2) || $past(CYCLE_STB, 3))
		else $error("event outside its slot");
	a_alarm_evt_state: assert property (EVT_VALID && !code[1] |-> ALARM == !code[0])
		else $error("alarm event disagrees with alarm");
	a_block_evt_state: assert property (EVT_VALID && code[1] |-> BLOCKED == !code[0])
		else $error("block event disagrees with blocked");
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == '0)
		else $error("read data outside its cycle");

	c_start: cover property ($rose(START));
	c_alarm: cover property ($rose(ALARM));
	c_blocked: cover property ($rose(BLOCKED));
	c_event: cover property (EVT_VALID && code == 2'h2);
endmodule

// *** verif/ctsup_front_model.sv ***
/*
 * Front end model: processing strobe every 16 clocks, time base,
 * measurement words and blocking pin. Assumes bench requests on clk.
 */
`timescale 1ns/100ps

module ctsup_front_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Requests from the bench
	input wire logic blk_req,
	input wire ctsup_pkg::ctsup_meas_t m_req,
	// Towards the supervisor
	output logic cycle_stb,
	output logic block_pin,
	output ctsup_pkg::ctsup_meas_t meas,
	output logic [31:0] time_now
);
	logic [3:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			cycle_stb <= 1'b0;
			time_now <= 32'h0000_0000;
		end else begin
			cnt_q <= cnt_q + 4'h1;
			cycle_stb <= (cnt_q == 4'hF);
			if (cycle_stb) begin
				time_now <= time_now + 32'h0000_0001;
			end
		end
	end

	// Pin settles far ahead of any delay end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			block_pin <= 1'b0;
			meas <= '0;
		end else begin
			block_pin <= blk_req;
			meas <= m_req;
		end
	end
endmodule

// *** verif/ctsup_supervisor_tb_top.sv ***
/*
 * Self-checking bench for the wiring supervisor with the front end model.
 * Assumes the package, design and model are compiled first.
 */
`timescale 1ns/100ps
`define CHK(w, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
	$display("wrong value %s exp %0h got %0h", w, e, s); end end

module ctsup_supervisor_tb_top;
	logic clock = 1'b0;
	logic arst_n = 1'b1;
	logic stb, blk_pin, start, alarm, blocked, notify, evt_valid;
	logic blk = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, tnow, rv;
	ctsup_pkg::ctsup_meas_t m = '0, meas, v, seen_m = '0;
	ctsup_pkg::ctsup_evt_t evt;
	int n_fail = 0, cmp_count = 0;
	int ev_n [4] = '{default: 0};
	logic [1:0] r;
	localparam ctsup_pkg::ctsup_meas_t FAULT = 128'h0000_0064_0064_0000_0000_0043_0021_0021;
	localparam ctsup_pkg::ctsup_meas_t HEALTHY = 128'h0064_0064_0064_0000_0000_0064_0000_0000;
	localparam ctsup_pkg::ctsup_meas_t CORN [4] = '{128'h0000_0064_0096_0000_0000_0043_0021_0021,
		128'h0000_0005_0005_0000_0000_0003_0002_0002,
		128'h0000_0064_0064_0021_0000_0043_0021_0021, FAULT};
	localparam logic [1:0] CRES [4] = '{2'b00, 2'b01, 2'b01, 2'b01};

	initial begin
		forever #2 clock = ~clock;
	end

	ctsup_front_model u_ctsup_front_model (.clk(clock), .rst_n(arst_n), .blk_req(blk), .m_req(m),
		.cycle_stb(stb), .block_pin(blk_pin), .meas(meas), .time_now(tnow));
	ctsup_supervisor u_ctsup_supervisor (.CLOCK(clock), .ARST_N(arst_n), .CE(1'b1),
		.CYCLE_STB(stb), .BLOCK_IN(blk_pin), .MEAS(meas), .TIME_NOW(tnow),
		.SETTINGS_BANK(3'h2), .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb),
		.RDATA(rdata), .START(start), .ALARM(alarm), .BLOCKED(blocked), .NOTIFY(notify),
		.EVT_VALID(evt_valid), .EVT(evt));

	// ----------------------------------------------------------------
	// Bus, stimulus and expectation helpers
	// ----------------------------------------------------------------
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Inputs change right after a strobe so pin and words settle before the next
	task automatic set_in(input ctsup_pkg::ctsup_meas_t x, input logic b);
		@(posedge clock iff stb);
		m <= x;
		blk <= b;
	endtask

	task automatic steps(input int n);
		repeat (n) @(posedge clock iff stb);
		repeat (4) @(posedge clock);
		#1;
	endtask

	function automatic logic exp_pick(input ctsup_pkg::ctsup_meas_t x, input logic [1:0] res);
		int mn, mx, df;
		mn = x.il1 < x.il2 ? x.il1 : x.il2;
		mn = mn < x.il3 ? mn : x.il3;
		mx = x.il1 > x.il2 ? x.il1 : x.il2;
		mx = mx > x.il3 ? mx : x.il3;
		df = res[1] ? x.i02 : x.i01;
		df = x.isum > df ? x.isum - df : df - x.isum;
		return mx <= int'(ctsup_pkg::HIGH_LIM_RESET) && mx >= int'(ctsup_pkg::LOW_LIM_RESET)
			&& mn * 10000 <= int'(ctsup_pkg::PHASE_RATIO_RESET) * mx
			&& x.ineg * 10000 >= int'(ctsup_pkg::SEQ_RATIO_RESET) * x.ipos
			&& (!res[0] || df >= int'(ctsup_pkg::SUM_DIFF_RESET));
	endfunction

	task automatic run_alarm(input int d);
		reg_wr(ctsup_pkg::OFS_ALARM_DELAY, 32'(d));
		set_in(FAULT, 1'b0);
		steps(1);
		`CHK("start", 1'b1, start)
		`CHK("alarm", logic'(d <= 1), alarm)
		if (d > 1) begin
			steps(d - 1);
			`CHK("alarm late", 1'b1, alarm)
		end
		set_in(HEALTHY, 1'b0);
		steps(1);
		`CHK("alarm off", 1'b0, alarm)
		`CHK("start off", 1'b0, start)
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Event monitor: counts codes, checks stamp and snapshot
	always @(posedge clock) begin
		if (stb === 1'b1) seen_m <= meas;
		if (evt_valid === 1'b1) begin
			ev_n[evt.code]++;
			`CHK("evt meas", seen_m, evt.meas)
			`CHK("evt fault", 3'b100, evt.fault)
			`CHK("evt stamp", tnow - 32'h0000_0001, evt.stamp)
		end
	end

	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		$display("watchdog expired");
		end_sim();
	end

	initial begin
		arst_n <= 1'b0;
		void'($urandom(32'hA22A_2264));
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		reg_rd(ctsup_pkg::OFS_CTRL, rv);
		`CHK("ctrl", 32'(ctsup_pkg::CTRL_RESET), rv)
		reg_rd(ctsup_pkg::OFS_ALARM_DELAY, rv);
		`CHK("delay", 32'(ctsup_pkg::ALARM_DELAY_RESET), rv)
		reg_rd(8'hFC, rv);
		`CHK("unmapped", 32'h0000_0000, rv)
		$display("test reset done");
		for (int i = 0; i < 13; i++) run_alarm(i == 0 ? 3 : 1);
		`CHK("alarm on evts", 13, ev_n[0])
		`CHK("alarm off evts", 13, ev_n[1])
		$display("test alarm done");
		reg_wr(ctsup_pkg::OFS_CTRL, 32'h0000_0010);
		reg_wr(ctsup_pkg::OFS_ALARM_DELAY, 32'h0000_0003);
		set_in(HEALTHY, 1'b1);
		steps(1);
		set_in(FAULT, 1'b1);
		steps(1);
		`CHK("blocked", 1'b1, blocked)
		`CHK("start blk", 1'b0, start)
		steps(3);
		`CHK("alarm blk", 1'b0, alarm)
		set_in(HEALTHY, 1'b0);
		steps(1);
		`CHK("blk off", 1'b0, blocked)
		`CHK("block on evts", 1, ev_n[2])
		`CHK("masked off", 0, ev_n[3])
		$display("test block done");
		reg_wr(ctsup_pkg::OFS_CTRL, 32'h0000_0030);
		set_in(FAULT, 1'b0);
		steps(1);
		set_in(FAULT, 1'b1);
		steps(1);
		`CHK("start drop", 1'b0, start)
		`CHK("blocked late", 1'b1, blocked)
		steps(2);
		`CHK("alarm held", 1'b0, alarm)
		set_in(HEALTHY, 1'b0);
		steps(1);
		reg_wr(ctsup_pkg::OFS_CTRL, 32'h0000_003C);
		set_in(FAULT, 1'b0);
		steps(1);
		`CHK("forced", 1'b1, blocked)
		reg_wr(ctsup_pkg::OFS_CTRL, 32'h0000_0030);
		set_in(HEALTHY, 1'b0);
		steps(1);
		`CHK("block evts", 3, ev_n[2])
		`CHK("unblock evts", 2, ev_n[3])
		$display("test late block done");
		reg_wr(ctsup_pkg::OFS_ALARM_DELAY, 32'h0000_03E8);
		for (int i = 0; i < 44; i++) begin
			for (int k = 0; k < 8; k++) v[k*16 +: 16] = 16'($urandom_range(0, 130));
			v.il1 = v.il1 >> 3;
			r = 2'($urandom_range(0, 3));
			if (i < 4) v = CORN[i];
			if (i < 4) r = CRES[i];
			reg_wr(ctsup_pkg::OFS_CTRL, 32'h0000_0030 | 32'(r));
			set_in(v, 1'b0);
			steps(1);
			`CHK("pickup", exp_pick(v, r), start)
		end
		set_in(HEALTHY, 1'b0);
		steps(1);
		$display("test pickup done");
		reg_rd(ctsup_pkg::OFS_HIST_INFO, rv);
		`CHK("hist info", 32'h0000_0C04, rv)
		reg_wr(ctsup_pkg::OFS_HIST_SEL, 32'h0000_0003);
		reg_rd(ctsup_pkg::OFS_HIST_DATA, rv);
		`CHK("hist word", {FAULT[9:0], 16'h0002, 3'b100, 3'h2}, rv)
		$display("test history done");
		end_sim();
	end
endmodule

bind ctsup_supervisor ctsup_supervisor_chk u_ctsup_supervisor_chk (.CLOCK(CLOCK), .ARST_N(ARST_N),
	.CYCLE_STB(CYCLE_STB), .RD(RD), .RDATA(RDATA), .START(START), .ALARM(ALARM),
	.BLOCKED(BLOCKED), .NOTIFY(NOTIFY), .EVT_VALID(EVT_VALID), .EVT(EVT));
